// file: fsgsr_regs.sv
// Function
// RQ1: lat comp delays gain one extra frame
// RQ2: line length aligned to frame start if enabled
// RQ3: dark rows aligned to frame start if enabled
// RQ4: padding rows aligned to frame start if enabled
// RQ5: integration time aligned if enabled
// RQ6: coarse/second gain aligned if enabled
// RQ7: region selection aligned if enabled
// RQ8: blank first frame after region change; the code blanks only while BLANK_ROI_BIT is set
// RQ9: snapshot: blank after subsample change if enabled
// RQ10: rolling: always blank after subsample change
// RQ11: mode clear: integration taken at overhead start
// RQ12: mode set: integration passes through continuously
// RQ13: triggered master: integration taken at integration start
// RQ14: software keeps mode bit zero elsewhere
// RQ15: cleared enable still governs integration update
// RQ16: gain readback: coarse 4:0, second 12:5
// RQ17: fine gain readback shows applied value
// RQ18: status writes ignored, reserved bits zero
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module fsgsr_regs
	import fsgsr_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              frameStart,
	input  wire logic              overheadStart,
	input  wire logic              integrationStart,
	input  wire logic              rollingShutter,
	input  wire logic              triggeredMaster,
	output fsgsr_applied_t         applied,
	output logic                   blankFrame
);

	////////////////////////////////////////////////////////////////////////////////
	// bus decode

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
		hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
	endfunction

	// misaligned addresses never hit, so they fall to the error answer

	logic [15:0] lineReg;
	logic [15:0] roiReg;
	logic [15:0] darkReg;
	logic [15:0] padReg;
	logic [15:0] expoReg;
	logic [15:0] gainReg;
	logic [15:0] fineReg;
	logic [15:0] syncReg;
	logic [15:0] subsReg;

	wire hitLine  = hit(paddr, IDX_LINE);
	wire hitRoi   = hit(paddr, IDX_ROI);
	wire hitDark  = hit(paddr, IDX_DARK);
	wire hitPad   = hit(paddr, IDX_PAD);
	wire hitExpo  = hit(paddr, IDX_EXPO);
	wire hitGain  = hit(paddr, IDX_GAIN);
	wire hitFine  = hit(paddr, IDX_FINE);
	wire hitSync  = hit(paddr, IDX_SYNC);
	wire hitSubs  = hit(paddr, IDX_SUBS);
	wire hitGStat = hit(paddr, IDX_GSTAT);
	wire hitFStat = hit(paddr, IDX_FSTAT);
	wire mapped   = hitLine | hitRoi | hitDark | hitPad | hitExpo | hitGain
		| hitFine | hitSync | hitSubs | hitGStat | hitFStat;

	// one wait state so that ready and read data come from flip-flops
	wire         accessOpen = psel && penable && !pready;
	wire         wrEn       = psel && penable && pready && pwrite && mapped;
	wire [15:0]  wd         = pwdata[15:0];

	// status words built from the values in use, reserved bits zero
	wire [15:0] gainStatus = {3'h0, applied.gain.second, applied.gain.coarse}; // [RQ16] [RQ18]
	wire [15:0] fineStatus = {4'h0, applied.gain.fine};                        // [RQ17] [RQ18]

	wire [15:0] rdMux =
		hitLine  ? lineReg :
		hitRoi   ? roiReg :
		hitDark  ? darkReg :
		hitPad   ? padReg :
		hitExpo  ? expoReg :
		hitGain  ? gainReg :
		hitFine  ? fineReg :
		hitSync  ? syncReg :
		hitSubs  ? subsReg :
		hitGStat ? gainStatus :
		hitFStat ? fineStatus : 16'h0000;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= accessOpen;
			pslverr <= accessOpen && !mapped;
			prdata  <= (accessOpen && !pwrite) ? {16'h0000, rdMux} : 32'h0000_0000;
		end
	end

	// status registers have no storage, so writes to them fall away [RQ18]
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lineReg <= RST_LINE;
			roiReg  <= RST_ROI;
			darkReg <= RST_DARK;
			padReg  <= RST_PAD;
			expoReg <= RST_EXPO;
			gainReg <= RST_GAIN;
			fineReg <= RST_FINE;
			syncReg <= RST_SYNC;
			subsReg <= RST_SUBS;
		end
		else if (wrEn)
		begin
			if (hitLine) lineReg <= wd & MASK_LINE;
			if (hitRoi)  roiReg  <= wd & MASK_ROI;
			if (hitDark) darkReg <= wd & MASK_DARK;
			if (hitPad)  padReg  <= wd & MASK_PAD;
			if (hitExpo) expoReg <= wd & MASK_EXPO;
			if (hitGain) gainReg <= wd & MASK_GAIN;
			if (hitFine) fineReg <= wd & MASK_FINE;
			if (hitSync) syncReg <= wd & MASK_SYNC;
			if (hitSubs) subsReg <= wd & MASK_SUBS;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// update alignment

	wire latComp = gainReg[GAIN_LATCOMP_BIT];
	wire expoMode = syncReg[EXPO_MODE_BIT];

	fsgsr_gain_t gainWritten;
	fsgsr_gain_t gainStage;

	// reset gain in use, built once for both the stage and the applied copy
	localparam fsgsr_gain_t GAIN_RESET = '{
		second: RST_GAIN[SECOND_LSB +: SECOND_W],
		coarse: RST_GAIN[COARSE_LSB +: COARSE_W],
		fine:   RST_FINE[FINE_W-1:0]
	};
	assign gainWritten.coarse = gainReg[COARSE_LSB +: COARSE_W];
	assign gainWritten.second = gainReg[SECOND_LSB +: SECOND_W];
	assign gainWritten.fine   = fineReg[FINE_W-1:0];

	// the stage catches each frame's written gain; with compensation on,
	// the applied gain is fed from it and so trails by one more frame
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			gainStage <= GAIN_RESET;
		else if (frameStart)
			gainStage <= gainWritten; // [RQ1]
	end

	wire fsgsr_gain_t gainSource = latComp ? gainStage : gainWritten; // [RQ1]

	// integration point: overhead start, or pass-through, or integration start
	wire expoStrobe = !expoMode ? overheadStart          // [RQ11]
		: triggeredMaster ? integrationStart              // [RQ13]
		: 1'b1;                                           // [RQ12]

	fsgsr_shadow #(
		.W   (LINE_W),
		.RST (RST_LINE[LINE_W-1:0])
	) uLine (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.setting (lineReg[LINE_W-1:0]),
		.alignEn (syncReg[SYNC_LINE_BIT]), // [RQ2]
		.strobe  (frameStart),
		.applied (applied.lineLength)
	);

	fsgsr_shadow #(
		.W   (DARK_W),
		.RST (RST_DARK[DARK_W-1:0])
	) uDark (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.setting (darkReg[DARK_W-1:0]),
		.alignEn (syncReg[SYNC_DARK_BIT]), // [RQ3]
		.strobe  (frameStart),
		.applied (applied.darkRows)
	);

	fsgsr_shadow #(
		.W   (PAD_W),
		.RST (RST_PAD[PAD_W-1:0])
	) uPad (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.setting (padReg[PAD_W-1:0]),
		.alignEn (syncReg[SYNC_PAD_BIT]), // [RQ4]
		.strobe  (frameStart),
		.applied (applied.padRows)
	);

	// the enable bit decides alignment whatever the mode bit picks as strobe
	fsgsr_shadow #(
		.W   (EXPO_W),
		.RST (RST_EXPO)
	) uExpo (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.setting (expoReg),
		.alignEn (syncReg[SYNC_EXPO_BIT]), // [RQ5] [RQ15]
		.strobe  (expoStrobe),
		.applied (applied.integration)
	);

	fsgsr_shadow #(
		.W   ($bits(fsgsr_gain_t)),
		.RST (GAIN_RESET)
	) uGain (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.setting (gainSource),
		.alignEn (syncReg[SYNC_GAIN_BIT]), // [RQ6]
		.strobe  (frameStart),
		.applied (applied.gain)
	);

	// region changes also feed the blanking logic below
	fsgsr_shadow #(
		.W   (ROI_W),
		.RST (RST_ROI[ROI_W-1:0])
	) uRoi (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.setting (roiReg[ROI_W-1:0]),
		.alignEn (syncReg[SYNC_ROI_BIT]), // [RQ7]
		.strobe  (frameStart),
		.applied (applied.roiActive)
	);

	// readout mode always waits for a frame start
	fsgsr_shadow #(
		.W   (SUBS_W),
		.RST (RST_SUBS[SUBS_W-1:0])
	) uSubs (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.setting (subsReg[SUBS_W-1:0]),
		.alignEn (1'b1),
		.strobe  (frameStart),
		.applied (applied.subsampleMode)
	);

	////////////////////////////////////////////////////////////////////////////////
	// frame blanking

	logic [ROI_W-1:0]  roiSeen;
	logic [SUBS_W-1:0] subsSeen;
	logic              frameStartD;
	logic              blankPending;

	wire roiChange  = (roiSeen != applied.roiActive) && syncReg[BLANK_ROI_BIT]; // [RQ8]
	wire subsChange = (subsSeen != applied.subsampleMode)
		&& (rollingShutter || syncReg[BLANK_SUBS_BIT]);                        // [RQ9] [RQ10]
	wire blankEvent = roiChange || subsChange;

	// a change seen one cycle after frame start belongs to the new frame;
	// any other change waits for the next one, and an event never loses
	wire next_pending = frameStartD ? 1'b0 : (blankPending || blankEvent);

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			roiSeen      <= RST_ROI[ROI_W-1:0];
			subsSeen     <= RST_SUBS[SUBS_W-1:0];
			frameStartD  <= 1'b0;
			blankPending <= 1'b0;
			blankFrame   <= 1'b0;
		end
		else
		begin
			roiSeen      <= applied.roiActive;
			subsSeen     <= applied.subsampleMode;
			frameStartD  <= frameStart;
			blankPending <= next_pending;
			if (frameStartD)
				blankFrame <= blankPending || blankEvent; // [RQ8] [RQ9] [RQ10]
		end
	end

endmodule

// file: fsgsr_pkg.sv
package fsgsr_pkg;

	// register indices; the byte address is four times the index
	localparam logic [5:0] IDX_LINE  = 6'h01;
	localparam logic [5:0] IDX_ROI   = 6'h03;
	localparam logic [5:0] IDX_DARK  = 6'h05;
	localparam logic [5:0] IDX_PAD   = 6'h06;
	localparam logic [5:0] IDX_EXPO  = 6'h09;
	localparam logic [5:0] IDX_GAIN  = 6'h0C;
	localparam logic [5:0] IDX_FINE  = 6'h0D;
	localparam logic [5:0] IDX_SYNC  = 6'h0E;
	localparam logic [5:0] IDX_GSTAT = 6'h15;
	localparam logic [5:0] IDX_FSTAT = 6'h16;
	localparam logic [5:0] IDX_SUBS  = 6'h28;

	localparam int ADDR_W = 8;

	// reset values
	localparam logic [15:0] RST_LINE = 16'h0000;
	localparam logic [15:0] RST_ROI  = 16'h0001;
	localparam logic [15:0] RST_DARK = 16'h0102;
	localparam logic [15:0] RST_PAD  = 16'h0000;
	localparam logic [15:0] RST_EXPO = 16'h0000;
	localparam logic [15:0] RST_GAIN = 16'h00A2;
	localparam logic [15:0] RST_FINE = 16'h0080;
	localparam logic [15:0] RST_SYNC = 16'h033F;
	localparam logic [15:0] RST_SUBS = 16'h0000;
	localparam logic [15:0] RST_STAT = 16'h0000;

	// writable bits of each register; the rest read as zero
	localparam logic [15:0] MASK_LINE = 16'hFFFF;
	localparam logic [15:0] MASK_ROI  = 16'h00FF;
	localparam logic [15:0] MASK_DARK = 16'h1FFF;
	localparam logic [15:0] MASK_PAD  = 16'h0FFF;
	localparam logic [15:0] MASK_EXPO = 16'hFFFF;
	localparam logic [15:0] MASK_GAIN = 16'h3FFF;
	localparam logic [15:0] MASK_FINE = 16'h0FFF;
	localparam logic [15:0] MASK_SYNC = 16'h073F;
	localparam logic [15:0] MASK_SUBS = 16'h001F;

	// frame_update_control bit positions
	localparam int SYNC_LINE_BIT  = 0;
	localparam int SYNC_DARK_BIT  = 1;
	localparam int SYNC_PAD_BIT   = 2;
	localparam int SYNC_EXPO_BIT  = 3;
	localparam int SYNC_GAIN_BIT  = 4;
	localparam int SYNC_ROI_BIT   = 5;
	localparam int BLANK_ROI_BIT  = 8;
	localparam int BLANK_SUBS_BIT = 9;
	localparam int EXPO_MODE_BIT  = 10;

	// gain register fields
	localparam int GAIN_LATCOMP_BIT = 13;
	localparam int COARSE_LSB       = 0;
	localparam int COARSE_W         = 5;
	localparam int SECOND_LSB       = 5;
	localparam int SECOND_W         = 8;
	localparam int FINE_W           = 12;

	localparam int LINE_W = 8;
	localparam int DARK_W = 8;
	localparam int PAD_W  = 12;
	localparam int EXPO_W = 16;
	localparam int ROI_W  = 8;
	localparam int SUBS_W = 5;

	typedef struct packed {
		logic [SECOND_W-1:0] second;
		logic [COARSE_W-1:0] coarse;
		logic [FINE_W-1:0]   fine;
	} fsgsr_gain_t;

	typedef struct packed {
		logic [LINE_W-1:0] lineLength;
		logic [DARK_W-1:0] darkRows;
		logic [PAD_W-1:0]  padRows;
		logic [EXPO_W-1:0] integration;
		fsgsr_gain_t       gain;
		logic [ROI_W-1:0]  roiActive;
		logic [SUBS_W-1:0] subsampleMode;
	} fsgsr_applied_t;

endpackage

// file: fsgsr_shadow.sv
`timescale 1ns/1ps
module fsgsr_shadow
	import fsgsr_pkg::*;
#(
	parameter int         W   = 8,
	parameter logic [W-1:0] RST = '0
)
(
	input  wire logic         sys_clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] setting,
	input  wire logic         alignEn,
	input  wire logic         strobe,
	output logic      [W-1:0] applied
);

	// aligned: copy only on the strobe; otherwise follow the setting
	wire         takeNow    = !alignEn || strobe;
	wire [W-1:0] next_value = takeNow ? setting : applied;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			applied <= RST;
		else
			applied <= next_value;
	end

endmodule

// file: fsgsr_regs_asserts.sv
`timescale 1ns/1ps
module fsgsr_regs_asserts
	import fsgsr_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              arst_n,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              frameStart,
	input wire logic              overheadStart,
	input wire logic              integrationStart,
	input wire logic              rollingShutter,
	input wire logic              triggeredMaster,
	input wire fsgsr_applied_t    applied,
	input wire logic              blankFrame
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!arst_n);
wire wrDone = psel && penable && pready && pwrite;
wire rdDone = psel && penable && pready && !pwrite;
////////////////////////////////////////////////////////////////
a_roi_cause: assert property ($changed(applied.roiActive) |->
	$past(frameStart) || $past(wrDone) || $past(wrDone, 2)) else $error("roi moved");
a_line_cause: assert property ($changed(applied.lineLength) |->
	$past(frameStart) || $past(wrDone) || $past(wrDone, 2)) else $error("line moved");
a_dark_cause: assert property ($changed(applied.darkRows) |->
	$past(frameStart) || $past(wrDone) || $past(wrDone, 2)) else $error("dark moved");
a_subs_frame: assert property ($changed(applied.subsampleMode) |-> $past(frameStart))
	else $error("subsample moved off frame");
a_blank_end: assert property ($fell(blankFrame) |-> $past(frameStart, 2))
	else $error("blank ended off frame");
a_gain_stat: assert property (rdDone && paddr == {IDX_GSTAT, 2'h0} |->
	prdata == {19'h0, $past(applied.gain.second), $past(applied.gain.coarse)})
	else $error("gain status wrong");
a_fine_stat: assert property (rdDone && paddr == {IDX_FSTAT, 2'h0} |->
	prdata == {20'h0, $past(applied.gain.fine)}) else $error("fine status wrong");
a_upper_zero: assert property (rdDone |-> prdata[31:16] == 16'h0)
	else $error("upper bits set");
a_error_clean: assert property (pslverr |-> pready && prdata == 32'h0)
	else $error("error read not clean");
c_blank: cover property ($rose(blankFrame));
c_err: cover property (pslverr);
c_gain_read: cover property (rdDone && paddr == {IDX_GSTAT, 2'h0});
endmodule
bind fsgsr_regs fsgsr_regs_asserts fsgsr_regs_asserts_inst (.*);

// file: fsgsr_regs_tb_top.sv
`timescale 1ns/1ps
module fsgsr_regs_tb_top
	import fsgsr_pkg::*;
;
logic              sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
logic              rollingShutter = 0, triggeredMaster = 0, pready, pslverr, blankFrame, err;
logic [ADDR_W-1:0] paddr = '0;
logic [31:0]       pwdata = '0, prdata, rd;
logic [2:0]        st = 3'h0;
fsgsr_applied_t    applied;
int                mismatches = 0, checkCount = 0, cyc = 0;
always #50 sys_clk = ~sys_clk;
fsgsr_regs fsgsr_regs_inst (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .frameStart(st[0]), .overheadStart(st[1]),
	.integrationStart(st[2]), .rollingShutter(rollingShutter),
	.triggeredMaster(triggeredMaster), .applied(applied), .blankFrame(blankFrame));
////////////////////////////////////////////////////////////////
task report_and_stop;
	$display("checks %0d mismatches %0d", checkCount, mismatches);
	if (mismatches == 0 && checkCount > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask
always @(posedge sys_clk)
begin
	cyc++;
	if (cyc == 5000)
	begin
		mismatches++;
		report_and_stop;
	end
end
task chk(input logic [31:0] got, input logic [31:0] exp);
	checkCount++;
	if (got !== exp)
	begin
		mismatches++;
		$display("BAD %0t got %h exp %h", $time, got, exp);
	end
endtask
task apb(input logic w, input logic [5:0] i, input logic [15:0] d);
	psel <= 1'h1;
	pwrite <= w;
	paddr <= {i, 2'h0};
	pwdata <= {16'h0, d};
	@(posedge sys_clk);
	penable <= 1'h1;
	do @(posedge sys_clk); while (pready !== 1'b1);
	rd = prdata;
	err = pslverr;
	psel <= 1'h0;
	penable <= 1'h0;
	@(posedge sys_clk);
endtask
// one-cycle sequencer pulse, then room for the blank flag to settle
task strobe(input logic [2:0] s);
	st <= s;
	@(posedge sys_clk);
	st <= 3'h0;
	repeat (3) @(posedge sys_clk);
endtask
task rdchk(input logic [5:0] i, input logic [15:0] e);
	apb(1'h0, i, 16'h0);
	chk(rd, {16'h0, e});
endtask
////////////////////////////////////////////////////////////////
logic [5:0]  ix[11] = '{6'h01, 6'h03, 6'h05, 6'h06, 6'h09, 6'h0C, 6'h0D, 6'h0E, 6'h15,
	6'h16, 6'h28};
logic [15:0] rv[11] = '{16'h0, 16'h1, 16'h0102, 16'h0, 16'h0, 16'h00A2, 16'h0080,
	16'h033F, 16'h00A2, 16'h0080, 16'h0};
task t_regs;
	foreach (ix[k]) rdchk(ix[k], rv[k]);
	apb(1'h0, 6'h3F, 16'h0);
	chk(32'(err), 32'h1);
	apb(1'h1, IDX_FSTAT, 16'hFFFF);
	rdchk(IDX_FSTAT, 16'h0080);
	$display("end regs");
endtask
task t_gain;
	apb(1'h1, IDX_GAIN, 16'h0123);
	apb(1'h1, IDX_FINE, 16'h0456);
	rdchk(IDX_GSTAT, 16'h00A2);
	strobe(3'h1);
	rdchk(IDX_GSTAT, 16'h0123);
	rdchk(IDX_FSTAT, 16'h0456);
	apb(1'h1, IDX_GAIN, 16'h2045);
	strobe(3'h1);
	rdchk(IDX_GSTAT, 16'h0123);
	strobe(3'h1);
	rdchk(IDX_GSTAT, 16'h0045);
	$display("end gain");
endtask
task t_expo;
	apb(1'h1, IDX_SYNC, 16'h0300);
	apb(1'h1, IDX_LINE, 16'h00AB);
	apb(1'h1, IDX_DARK, 16'h0007);
	apb(1'h1, IDX_EXPO, 16'h1234);
	apb(1'h1, IDX_PAD, 16'h0ABC);
	@(posedge sys_clk);
	chk(32'(applied.padRows), 32'hABC);
	chk(32'(applied.lineLength), 32'hAB);
	chk(32'(applied.darkRows), 32'h07);
	chk(32'(applied.integration), 32'h1234);
	apb(1'h1, IDX_SYNC, 16'h033F);
	apb(1'h1, IDX_EXPO, 16'h4321);
	apb(1'h1, IDX_PAD, 16'h0123);
	@(posedge sys_clk);
	chk(32'(applied.padRows), 32'hABC);
	strobe(3'h1);
	chk(32'(applied.padRows), 32'h123);
	chk(32'(applied.integration), 32'h1234);
	strobe(3'h2);
	chk(32'(applied.integration), 32'h4321);
	apb(1'h1, IDX_SYNC, 16'h073F);
	triggeredMaster <= 1'h1;
	apb(1'h1, IDX_EXPO, 16'h5555);
	strobe(3'h2);
	chk(32'(applied.integration), 32'h4321);
	strobe(3'h4);
	chk(32'(applied.integration), 32'h5555);
	triggeredMaster <= 1'h0;
	apb(1'h1, IDX_EXPO, 16'h0777);
	strobe(3'h0);
	chk(32'(applied.integration), 32'h0777);
	apb(1'h1, IDX_SYNC, 16'h033F);
	$display("end expo");
endtask
task t_blank;
	apb(1'h1, IDX_ROI, 16'h0003);
	strobe(3'h0);
	chk(32'(applied.roiActive), 32'h01);
	strobe(3'h1);
	chk(32'(applied.roiActive), 32'h03);
	chk(32'(blankFrame), 32'h1);
	strobe(3'h1);
	chk(32'(blankFrame), 32'h0);
	apb(1'h1, IDX_SYNC, 16'h013F);
	rollingShutter <= 1'h1;
	apb(1'h1, IDX_SUBS, 16'h0002);
	strobe(3'h1);
	chk(32'(blankFrame), 32'h1);
	rollingShutter <= 1'h0;
	apb(1'h1, IDX_SUBS, 16'h0004);
	strobe(3'h1);
	chk(32'(blankFrame), 32'h0);
	chk(32'(applied.subsampleMode), 32'h04);
	apb(1'h1, IDX_SYNC, 16'h033F);
	apb(1'h1, IDX_SUBS, 16'h0001);
	strobe(3'h1);
	chk(32'(blankFrame), 32'h1);
	$display("end blank");
endtask
initial
begin
	repeat (20) @(posedge sys_clk);
	arst_n <= 1'h1;
	@(posedge sys_clk);
	t_regs;
	t_gain;
	t_expo;
	t_blank;
	report_and_stop;
end
endmodule
